/* design/talr_core.sv */
`timescale 1ns/1ns
// register, alarm, trip and conversion control core of the two-channel sensor
module talr_core #(
	parameter int unsigned RATE_BASE_CYC = talr_pkg::RATE_BASE_CYC, // 250 ms in clocks
	parameter bit          DIODE_ALERT   = 1'b1,   // variant with continuity alarm
	parameter logic [7:0]  MAKER_ID      = 8'hA5,  // arbitrary value
	parameter logic [7:0]  REVISION_ID   = 8'h01   // arbitrary value
) (
	// clock and reset
	input  wire logic                clock_i,
	input  wire logic                reset_n_i,
	// two-wire link, open drain data
	input  wire logic                scl_i,
	input  wire logic                sda_i,
	output logic                     sda_o,
	output logic                     sda_oe_o,
	// alarm outputs
	output logic                     alert_o,
	output logic                     alert_oe_o,
	output logic                     thermal_trip_output_o,
	// measurement front end
	input  wire talr_pkg::talr_meas_t meas_i,
	output logic                     conv_start_o,
	output logic                     conv_abort_o,
	output logic                     conv_busy_o
);

	typedef enum logic [2:0] {L_IDLE, L_ADDR, L_ACK, L_RX, L_TX, L_TXACK} talr_link_t;

	talr_link_t lst_r;
	logic [2:0] scl_q, sda_q;
	logic       scl_rise, scl_fall, start_c, stop_c;
	logic [7:0] sh_r, tx_r, ptr_r, rd_data;
	logic [2:0] bit_r;
	logic       rw_r, ara_r, cmd_next_r, nack_r, lead_r;
	logic       wr_stb_r, os_req_r, stat_rd_r, ara_ok_r;
	logic [7:0] cfg_r, rate_r, lhi_r, llo_r, rhi_r, rlo_r;
	logic [7:0] rtrip_r, ltrip_r, margin_r, queue_r;
	logic [7:0] ltemp_r, rtemp_r, lfrac_r, rfrac_r;
	logic       busy_r, os_run_r, standby, res_ok;
	logic [31:0] tmr_r, interval;
	logic [2:0] rshift;
	logic [7:0] loc_w, rem_w, rel_l, rel_r;
	logic [4:0] cond, cond_r, fl_r, fl_set, fl_clr;
	logic [3:0] qual;
	logic [1:0] qlen, trip_r;
	logic       alert_latch_r, alert_set, cond_any, latch_clr;

	//////////////////////////////////////////////////////////////////////////
	// link sampling: first stage feeds only the second
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
		end else begin
			scl_q <= {scl_q[1:0], scl_i};
			sda_q <= {sda_q[1:0], sda_i};
		end
	end

	assign scl_rise = scl_q[1] & ~scl_q[2];
	assign scl_fall = ~scl_q[1] & scl_q[2];
	assign start_c  = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
	assign stop_c   = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

	// read data selected by the command pointer
	always_comb begin
		case (ptr_r)
			talr_pkg::CMD_LTEMP:   rd_data = ltemp_r;
			talr_pkg::CMD_RTEMP:   rd_data = rtemp_r;
			talr_pkg::CMD_STATUS:  rd_data = {busy_r, fl_r, trip_r};
			talr_pkg::CMD_CFG_RD:  rd_data = cfg_r;
			talr_pkg::CMD_RATE_RD: rd_data = rate_r;
			talr_pkg::CMD_LHI_RD:  rd_data = lhi_r;
			talr_pkg::CMD_LLO_RD:  rd_data = llo_r;
			talr_pkg::CMD_RHI_RD:  rd_data = rhi_r;
			talr_pkg::CMD_RLO_RD:  rd_data = rlo_r;
			talr_pkg::CMD_RFRAC:   rd_data = rfrac_r;
			talr_pkg::CMD_LFRAC:   rd_data = lfrac_r;
			talr_pkg::CMD_RTRIP:   rd_data = rtrip_r;
			talr_pkg::CMD_LTRIP:   rd_data = ltrip_r;
			talr_pkg::CMD_MARGIN:  rd_data = margin_r;
			talr_pkg::CMD_QUEUE:   rd_data = queue_r;
			talr_pkg::CMD_MAKER:   rd_data = MAKER_ID;
			talr_pkg::CMD_REV:     rd_data = REVISION_ID;
			default:               rd_data = 8'h00;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// link slave: bits sampled on scl rise, data driven after scl fall
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lst_r      <= L_IDLE;
			sh_r       <= 8'h00;
			tx_r       <= 8'h00;
			ptr_r      <= talr_pkg::RST_PTR;
			bit_r      <= 3'h0;
			rw_r       <= 1'b0;
			ara_r      <= 1'b0;
			cmd_next_r <= 1'b0;
			nack_r     <= 1'b1;
			lead_r     <= 1'b0;
			sda_oe_o   <= 1'b0;
			wr_stb_r   <= 1'b0;
			os_req_r   <= 1'b0;
			stat_rd_r  <= 1'b0;
			ara_ok_r   <= 1'b0;
		end else begin
			wr_stb_r  <= 1'b0;
			os_req_r  <= 1'b0;
			stat_rd_r <= 1'b0;
			ara_ok_r  <= 1'b0;
			if (stop_c) begin
				lst_r    <= L_IDLE;
				sda_oe_o <= 1'b0;
			end else if (start_c) begin
				lst_r    <= L_ADDR;
				bit_r    <= 3'h0;
				sda_oe_o <= 1'b0;
				lead_r   <= 1'b1;
			end else if (scl_rise) begin
				case (lst_r)
					L_ADDR, L_RX: sh_r <= {sh_r[6:0], sda_q[1]};
					L_TX: if (tx_r[7] && !sda_q[1]) begin
						lst_r    <= L_IDLE;
						sda_oe_o <= 1'b0;
					end
					L_TXACK: nack_r <= sda_q[1];
					default: ;
				endcase
			end else if (scl_fall && lead_r) begin
				// the scl fall that closes a start carries no bit
				lead_r <= 1'b0;
			end else if (scl_fall) begin
				case (lst_r)
					L_ADDR: begin
						bit_r <= bit_r + 3'h1;
						if (bit_r == 3'h7) begin
							if (sh_r[7:1] == talr_pkg::OWN_ADDR) begin
								lst_r      <= L_ACK;
								sda_oe_o   <= 1'b1;
								rw_r       <= sh_r[0];
								ara_r      <= 1'b0;
								cmd_next_r <= ~sh_r[0];
							end else if (sh_r[7:1] == talr_pkg::ARA_ADDR && sh_r[0]
							             && alert_latch_r) begin
								lst_r    <= L_ACK;
								sda_oe_o <= 1'b1;
								rw_r     <= 1'b1;
								ara_r    <= 1'b1;
							end else begin
								lst_r <= L_IDLE;
							end
						end
					end
					L_ACK: begin
						if (rw_r) begin
							lst_r <= L_TX;
							if (ara_r) begin
								tx_r     <= {talr_pkg::OWN_ADDR, 1'b0};
								sda_oe_o <= ~talr_pkg::OWN_ADDR[6];
							end else begin
								tx_r     <= rd_data;
								sda_oe_o <= ~rd_data[7];
							end
						end else begin
							lst_r    <= L_RX;
							sda_oe_o <= 1'b0;
						end
					end
					L_RX: begin
						bit_r <= bit_r + 3'h1;
						if (bit_r == 3'h7) begin
							lst_r    <= L_ACK;
							sda_oe_o <= 1'b1;
							if (cmd_next_r) begin
								ptr_r      <= sh_r;
								os_req_r   <= (sh_r == talr_pkg::CMD_ONESHOT);
								cmd_next_r <= 1'b0;
							end else begin
								wr_stb_r <= 1'b1;
							end
						end
					end
					L_TX: begin
						bit_r <= bit_r + 3'h1;
						if (bit_r == 3'h7) begin
							lst_r     <= L_TXACK;
							sda_oe_o  <= 1'b0;
							ara_ok_r  <= ara_r;
							stat_rd_r <= ~ara_r && (ptr_r == talr_pkg::CMD_STATUS);
						end else begin
							tx_r     <= {tx_r[6:0], 1'b0};
							sda_oe_o <= ~tx_r[6];
						end
					end
					L_TXACK: begin
						if (!nack_r && !ara_r) begin
							lst_r    <= L_TX;
							tx_r     <= rd_data;
							sda_oe_o <= ~rd_data[7];
						end else begin
							lst_r <= L_IDLE;
						end
					end
					default: lst_r <= L_IDLE;
				endcase
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// host-written registers; sh_r holds still until the next scl rise
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cfg_r    <= talr_pkg::RST_CFG;
			rate_r   <= talr_pkg::RST_RATE;
			lhi_r    <= talr_pkg::RST_LHI;
			llo_r    <= talr_pkg::RST_LLO;
			rhi_r    <= talr_pkg::RST_RHI;
			rlo_r    <= talr_pkg::RST_RLO;
			rtrip_r  <= talr_pkg::RST_RTRIP;
			ltrip_r  <= talr_pkg::RST_LTRIP;
			margin_r <= talr_pkg::RST_MARGIN;
			queue_r  <= talr_pkg::RST_QUEUE;
		end else if (wr_stb_r) begin
			case (ptr_r)
				talr_pkg::CMD_CFG_WR:  cfg_r    <= sh_r & talr_pkg::CFG_WMASK;
				talr_pkg::CMD_RATE_WR: rate_r   <= sh_r;
				talr_pkg::CMD_LHI_WR:  lhi_r    <= sh_r;
				talr_pkg::CMD_LLO_WR:  llo_r    <= sh_r;
				talr_pkg::CMD_RHI_WR:  rhi_r    <= sh_r;
				talr_pkg::CMD_RLO_WR:  rlo_r    <= sh_r;
				talr_pkg::CMD_RTRIP:   rtrip_r  <= sh_r;
				talr_pkg::CMD_LTRIP:   ltrip_r  <= sh_r;
				talr_pkg::CMD_MARGIN:  margin_r <= sh_r;
				talr_pkg::CMD_QUEUE:   queue_r  <= sh_r;
				default: ;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// conversion sequencer and rate timer
	assign standby  = cfg_r[talr_pkg::CFG_STBY_BIT];
	assign rshift   = (rate_r[2:0] >= talr_pkg::RATE_FAST) ? 3'h0
	                : talr_pkg::RATE_FAST - rate_r[2:0];
	assign interval = 32'(RATE_BASE_CYC) << rshift;
	// a standby request drops an automatic conversion's result
	assign res_ok   = busy_r && meas_i.done && (os_run_r || !standby);

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			busy_r       <= 1'b0;
			os_run_r     <= 1'b0;
			tmr_r        <= 32'h0; // first conversion right after reset
			conv_start_o <= 1'b0;
			conv_abort_o <= 1'b0;
		end else begin
			conv_start_o <= 1'b0;
			conv_abort_o <= 1'b0;
			if (os_req_r && !(busy_r && os_run_r)) begin
				// an automatic conversion in flight carries on as the one-shot
				conv_start_o <= !busy_r || meas_i.done;
				busy_r       <= 1'b1;
				os_run_r     <= 1'b1;
				tmr_r        <= interval;
			end else if (busy_r && !os_run_r && standby) begin
				busy_r       <= 1'b0;
				conv_abort_o <= 1'b1;
			end else if (busy_r && meas_i.done) begin
				busy_r   <= 1'b0;
				os_run_r <= 1'b0; // back to standby if selected
			end else if (!standby) begin
				// alarm state is not looked at here
				if (tmr_r == 32'h0) begin
					if (!busy_r) begin
						conv_start_o <= 1'b1;
						busy_r       <= 1'b1;
						tmr_r        <= interval;
					end
				end else begin
					tmr_r <= tmr_r - 32'h1;
				end
			end
		end
	end

	assign conv_busy_o = busy_r;

	//////////////////////////////////////////////////////////////////////////
	// limit comparison and fault queue
	assign loc_w = meas_i.local_t.whole;
	assign rem_w = meas_i.open ? talr_pkg::OPEN_TEMP : meas_i.remote.whole;
	assign cond  = {loc_w >= lhi_r, loc_w < llo_r, rem_w >= rhi_r, rem_w < rlo_r,
	                meas_i.open};
	assign qlen  = (queue_r[talr_pkg::FQ_HI_BIT:talr_pkg::FQ_LO_BIT] == 2'h1) ? 2'h2
	             : (queue_r[talr_pkg::FQ_HI_BIT:talr_pkg::FQ_LO_BIT] == 2'h3) ? 2'h3
	             : 2'h1;

	for (genvar i = 0; i < 4; i++) begin : g_queue
		logic [1:0] cnt_r;
		// saturating run length; any in-limit result restarts it
		always_ff @(posedge clock_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				cnt_r <= 2'h0;
			end else if (res_ok) begin
				cnt_r <= !cond[i+1] ? 2'h0 : (cnt_r == 2'h3) ? 2'h3 : cnt_r + 2'h1;
			end
		end
		assign qual[i] = cond[i+1] && ((3'(cnt_r) + 3'h1) >= 3'(qlen));
	end

	//////////////////////////////////////////////////////////////////////////
	// results and sticky status flags; a set beats a same-cycle clear
	assign fl_set = {qual & {4{res_ok}}, res_ok & meas_i.open};
	assign fl_clr = {5{stat_rd_r && !busy_r}} & ~cond_r;

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ltemp_r <= 8'h00;
			rtemp_r <= 8'h00;
			lfrac_r <= 8'h00;
			rfrac_r <= 8'h00;
			cond_r  <= 5'h00;
			fl_r    <= 5'h00;
		end else begin
			fl_r <= (fl_r & ~fl_clr) | fl_set;
			if (res_ok) begin
				ltemp_r <= loc_w;
				rtemp_r <= rem_w;
				lfrac_r <= {meas_i.local_t.frac, 5'h00};
				rfrac_r <= {meas_i.open ? 3'h0 : meas_i.remote.frac, 5'h00};
				cond_r  <= cond;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// alarm latch, independent of the status flags
	assign alert_set = res_ok && ((|qual) || (DIODE_ALERT && meas_i.open));
	assign cond_any  = (|cond_r[4:1]) || (DIODE_ALERT && cond_r[0]);
	assign latch_clr = (stat_rd_r || ara_ok_r) && !cond_any;

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			alert_latch_r <= 1'b0;
			alert_oe_o    <= 1'b0;
			alert_o       <= 1'b0;
			sda_o         <= 1'b0;
		end else begin
			alert_latch_r <= alert_set || (alert_latch_r && !latch_clr);
			alert_oe_o    <= alert_latch_r && !cfg_r[talr_pkg::CFG_MASK_BIT];
			alert_o       <= 1'b0;
			sda_o         <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// trip output with release margin, floored at zero
	assign rel_l = (ltrip_r > margin_r) ? ltrip_r - margin_r : 8'h00;
	assign rel_r = (rtrip_r > margin_r) ? rtrip_r - margin_r : 8'h00;

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			trip_r                <= 2'h0;
			thermal_trip_output_o <= 1'b0;
		end else begin
			if (res_ok) begin
				if (loc_w >= ltrip_r) trip_r[0] <= 1'b1;
				else if (loc_w < rel_l) trip_r[0] <= 1'b0;
				if (rem_w >= rtrip_r) trip_r[1] <= 1'b1;
				else if (rem_w < rel_r) trip_r[1] <= 1'b0;
			end
			thermal_trip_output_o <= |trip_r;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// checks
	property p_mask;
		@(posedge clock_i) disable iff (!reset_n_i)
		$past(cfg_r[talr_pkg::CFG_MASK_BIT]) |-> !alert_oe_o;
	endproperty
	a_mask: assert property (p_mask) else $error("alarm driven while masked");

	property p_od;
		@(posedge clock_i) disable iff (!reset_n_i)
		alert_oe_o |-> !alert_o;
	endproperty
	a_od: assert property (p_od) else $error("alarm pin driven high");

	property p_latch_clr;
		@(posedge clock_i) disable iff (!reset_n_i)
		$fell(alert_latch_r) |-> $past((stat_rd_r || ara_ok_r) && !cond_any);
	endproperty
	a_latch_clr: assert property (p_latch_clr) else $error("latch cleared early");

	property p_latch_set;
		@(posedge clock_i) disable iff (!reset_n_i)
		res_ok && (|qual) |=> alert_latch_r;
	endproperty
	a_latch_set: assert property (p_latch_set) else $error("alarm not latched");

	property p_diode;
		@(posedge clock_i) disable iff (!reset_n_i)
		DIODE_ALERT && res_ok && meas_i.open |=> alert_latch_r && fl_r[0];
	endproperty
	a_diode: assert property (p_diode) else $error("diode fault missed");

	property p_queue;
		@(posedge clock_i) disable iff (!reset_n_i)
		res_ok && cond[4] && !cond_r[4] && qlen != 2'h1 |=> !$rose(fl_r[4]);
	endproperty
	a_queue: assert property (p_queue) else $error("queue length ignored");

	property p_trip_set;
		@(posedge clock_i) disable iff (!reset_n_i)
		res_ok && loc_w >= ltrip_r |=> trip_r[0] ##1 thermal_trip_output_o;
	endproperty
	a_trip_set: assert property (p_trip_set) else $error("trip not raised");

	property p_trip_rel;
		@(posedge clock_i) disable iff (!reset_n_i)
		$fell(trip_r[0]) |-> $past(res_ok && loc_w < rel_l);
	endproperty
	a_trip_rel: assert property (p_trip_rel) else $error("trip released early");

	property p_os_ign;
		@(posedge clock_i) disable iff (!reset_n_i)
		os_req_r && busy_r && os_run_r |=> !conv_start_o;
	endproperty
	a_os_ign: assert property (p_os_ign) else $error("one-shot not ignored");

	property p_os_start;
		@(posedge clock_i) disable iff (!reset_n_i)
		os_req_r && !busy_r |=> conv_start_o && busy_r && os_run_r;
	endproperty
	a_os_start: assert property (p_os_start) else $error("one-shot not started");

	property p_os_tmr;
		@(posedge clock_i) disable iff (!reset_n_i)
		os_req_r && !busy_r && !standby |=> tmr_r == $past(interval);
	endproperty
	a_os_tmr: assert property (p_os_tmr) else $error("rate timer not restarted");

	property p_auto;
		@(posedge clock_i) disable iff (!reset_n_i)
		!standby && tmr_r == 32'h0 && !busy_r && !os_req_r |=> conv_start_o;
	endproperty
	a_auto: assert property (p_auto) else $error("automatic conversion missed");

	property p_flag_clr;
		@(posedge clock_i) disable iff (!reset_n_i)
		$fell(fl_r[4]) |-> $past(stat_rd_r && !busy_r && !cond_r[4]);
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flag cleared early");

	property p_lost;
		@(posedge clock_i) disable iff (!reset_n_i)
		lst_r == L_TX && scl_rise && tx_r[7] && !sda_q[1] |=> !sda_oe_o ##1 !sda_oe_o;
	endproperty
	a_lost: assert property (p_lost) else $error("kept driving after loss");

endmodule : talr_core

/* design/talr_pkg.sv */
// constants and carrier types for the thermal alarm register logic
package talr_pkg;

	// clock and conversion timing
	localparam int unsigned CLK_HZ        = 25_000_000;
	localparam int unsigned RATE_BASE_MS  = 250;           // interval at the fastest codes
	localparam int unsigned RATE_BASE_CYC = CLK_HZ / 1000 * RATE_BASE_MS;
	localparam logic [2:0]  RATE_FAST     = 3'h6;          // codes at or above run fastest

	// link addresses
	localparam logic [6:0] OWN_ADDR = 7'h4C;               // 1001 100
	localparam logic [6:0] ARA_ADDR = 7'h0C;               // 0001 100

	// command byte codes
	localparam logic [7:0] CMD_LTEMP  = 8'h00;
	localparam logic [7:0] CMD_RTEMP  = 8'h01;
	localparam logic [7:0] CMD_STATUS = 8'h02;
	localparam logic [7:0] CMD_CFG_RD = 8'h03;
	localparam logic [7:0] CMD_RATE_RD = 8'h04;
	localparam logic [7:0] CMD_LHI_RD = 8'h05;
	localparam logic [7:0] CMD_LLO_RD = 8'h06;
	localparam logic [7:0] CMD_RHI_RD = 8'h07;
	localparam logic [7:0] CMD_RLO_RD = 8'h08;
	localparam logic [7:0] CMD_CFG_WR = 8'h09;
	localparam logic [7:0] CMD_RATE_WR = 8'h0A;
	localparam logic [7:0] CMD_LHI_WR = 8'h0B;
	localparam logic [7:0] CMD_LLO_WR = 8'h0C;
	localparam logic [7:0] CMD_RHI_WR = 8'h0D;
	localparam logic [7:0] CMD_RLO_WR = 8'h0E;
	localparam logic [7:0] CMD_ONESHOT = 8'h0F;
	localparam logic [7:0] CMD_RFRAC  = 8'h10;
	localparam logic [7:0] CMD_LFRAC  = 8'h11;
	localparam logic [7:0] CMD_RTRIP  = 8'h19;
	localparam logic [7:0] CMD_LTRIP  = 8'h20;
	localparam logic [7:0] CMD_MARGIN = 8'h21;
	localparam logic [7:0] CMD_QUEUE  = 8'h22;
	localparam logic [7:0] CMD_MAKER  = 8'hFE;
	localparam logic [7:0] CMD_REV    = 8'hFF;

	// reset values
	localparam logic [7:0] RST_CFG    = 8'h00;
	localparam logic [7:0] RST_RATE   = 8'h07;
	localparam logic [7:0] RST_LHI    = 8'h55;
	localparam logic [7:0] RST_LLO    = 8'h00;
	localparam logic [7:0] RST_RHI    = 8'h5F;
	localparam logic [7:0] RST_RLO    = 8'h00;
	localparam logic [7:0] RST_RTRIP  = 8'h7D;
	localparam logic [7:0] RST_LTRIP  = 8'h55;
	localparam logic [7:0] RST_MARGIN = 8'h0A;
	localparam logic [7:0] RST_QUEUE  = 8'h86;
	localparam logic [7:0] RST_PTR    = 8'h00;
	localparam logic [7:0] OPEN_TEMP  = 8'hFF;             // remote reading on a diode fault

	// field positions
	localparam int unsigned CFG_MASK_BIT = 7;
	localparam int unsigned CFG_STBY_BIT = 6;
	localparam logic [7:0]  CFG_WMASK    = 8'hC0;          // reserved bits read zero
	localparam int unsigned FQ_HI_BIT    = 2;
	localparam int unsigned FQ_LO_BIT    = 1;

	// one channel's result: whole degrees and eighths
	typedef struct packed {
		logic [7:0] whole;
		logic [2:0] frac;
	} talr_temp_t;

	// result handed over by the measurement front end
	typedef struct packed {
		logic       done;     // one-cycle pulse at the end of a conversion
		logic       open;     // remote diode found open or shorted
		talr_temp_t local_t;
		talr_temp_t remote;
	} talr_meas_t;

endpackage : talr_pkg

/* testbench/talr_host.sv */
// bus master model that drives the sensor's two-wire link
`timescale 1ns/1ns
module talr_host (
	// link pins, open drain data
	output logic      scl_o,
	output logic      sda_low_o,
	input  wire logic sda_i
);
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// one bit; data moves only while the clock is low, sampled mid-high
	task automatic put(input logic b, output logic s);
		sda_low_o = ~b;
		#80 scl_o = 1'b1;
		#80 s = sda_i;
		#80 scl_o = 1'b0;
		#80;
	endtask : put
	// start or repeated start; the wait lets the slave drop its ack first
	task automatic start;
		sda_low_o = 1'b0;
		#160 scl_o = 1'b1;
		#80 sda_low_o = 1'b1;
		#80 scl_o = 1'b0;
		#80;
	endtask : start
	// stop leaves both lines released to the pull-up
	task automatic stop;
		sda_low_o = 1'b1;
		#80 scl_o = 1'b1;
		#80 sda_low_o = 1'b0;
		#160;
	endtask : stop
	// byte msb first, then a released ninth bit to see the ack
	task automatic xb(input logic [7:0] x, output logic [7:0] q, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) put(x[i], q[i]);
		put(1'b1, a);
		ack = ~a;
	endtask : xb
endmodule : talr_host

/* testbench/tb_talr_core.sv */
// self-checking bench for the thermal alarm register logic core
`timescale 1ns/1ns
module tb_talr_core;
	logic                 clock_i = 1'b0;
	logic                 reset_n_i = 1'b0;
	talr_pkg::talr_meas_t meas = '0;
	logic                 scl, sda_low, sda_oe, alert_oe, trip, cstart, cabort, ack, nk;
	wire                  sda = ~(sda_low | sda_oe); // pulled-up open drain line
	logic [7:0]           lt = 8'h00, d;
	logic                 tr = 1'b0, op = 1'b0;
	logic                 busy, al, sdo;
	int                   cnt = 0, n_conv = 0, c0 = 0, bad_count = 0, n_tests = 0, seed = 64715;
	// reset values plus one unmapped code, as {command, expected}
	logic [15:0] rv [13] = '{16'h0300, 16'h0407, 16'h0555, 16'h0600, 16'h075F, 16'h0800,
		16'h1000, 16'h1100, 16'h197D, 16'h2055, 16'h210A, 16'h2286, 16'h3000};
	logic [7:0]  cn [6] = '{8'h55, 8'h4B, 8'h4A, 8'h4B, 8'h54, 8'h56};
	always #20 clock_i = ~clock_i;
	talr_core #(.RATE_BASE_CYC(64)) u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(sda_oe), .alert_o(al),
		.alert_oe_o(alert_oe), .thermal_trip_output_o(trip), .meas_i(meas),
		.conv_start_o(cstart), .conv_abort_o(cabort), .conv_busy_o(busy));
	talr_host u_host (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));
	////////////////////////////////////////////////////////////////////////////////
	// front end stand-in: result ten clocks after a start, dropped on abort
	always @(posedge clock_i) begin
		#1 meas.done = 1'b0;
		if (cstart) cnt = 10;
		else if (cabort) cnt = 0;
		else if (cnt == 1) begin
			meas = {1'b1, op, lt, 14'h0000};
			n_conv++;
			cnt = 0;
		end else if (cnt > 0) cnt--;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch at %0t: saw %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : finish_test
	// trip holds between the limit and limit less margin
	function automatic logic exp_trip(input logic [7:0] t, input logic p);
		return (t >= talr_pkg::RST_LTRIP) ? 1'b1
		     : ((t < talr_pkg::RST_LTRIP - talr_pkg::RST_MARGIN) ? 1'b0 : p);
	endfunction : exp_trip
	task automatic wr(input logic [7:0] c, input logic [7:0] x, input bit two);
		u_host.start();
		u_host.xb(8'h98, d, ack);
		u_host.xb(c, d, ack);
		if (two) u_host.xb(x, d, ack);
		u_host.stop();
	endtask : wr
	// receive byte from address a, master nacks the data
	task automatic rx(input logic [7:0] a);
		u_host.start();
		u_host.xb(a, d, ack);
		u_host.xb(8'hFF, d, nk);
		u_host.stop();
	endtask : rx
	task automatic rd(input logic [7:0] c);
		u_host.start();
		u_host.xb(8'h98, d, nk);
		u_host.xb(c, d, nk);
		rx(8'h99);
	endtask : rd
	// caller sets c0 first, since a result may land before the wait starts
	task automatic wait_conv;
		for (int i = 0; i < 9000 && n_conv == c0; i++) @(posedge clock_i);
		if (n_conv == c0) begin
			chk(8'hFF, 8'h00);
			finish_test();
		end
		repeat (4) @(posedge clock_i);
		#1;
	endtask : wait_conv
	task automatic os;
		c0 = n_conv;
		wr(8'h0F, 8'h00, 1'b0);
		wait_conv();
		chk(8'(busy), 8'h00);
	endtask : os
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clock_i);
		#1 reset_n_i = 1'b1;
		repeat (4) @(posedge clock_i);
		#1;
		rx(8'h99);
		chk(d, 8'h00);
		foreach (rv[i]) begin
			rd(rv[i][15:8]);
			chk(d, rv[i][7:0]);
		end
		wr(8'h09, 8'hFF, 1'b1);
		rd(8'h03);
		chk(d, 8'hC0);
		wr(8'h0B, 8'h40, 1'b1);
		wr(8'h09, 8'h40, 1'b1);
		// queue of three from reset: alarm on the third hot result only
		lt = 8'h48;
		for (int i = 0; i < 3; i++) begin
			os();
			chk(8'(alert_oe), {7'h00, i == 2});
		end
		c0 = n_conv;
		repeat (300) @(posedge clock_i);
		#1;
		chk(8'(n_conv - c0), 8'h00);
		rx(8'h19);
		chk(d, 8'h98);
		chk(8'(alert_oe), 8'h01);
		lt = 8'h30;
		os();
		rx(8'h19);
		chk(8'(alert_oe), 8'h00);
		rd(8'h02);
		chk(d, 8'h40);
		rd(8'h02);
		chk(d, 8'h00);
		rx(8'h19);
		chk(8'(ack), 8'h00);
		// queue of two, written with bit 7 set and reserved bits clear
		wr(8'h22, 8'h82, 1'b1);
		rd(8'h22);
		chk(d, 8'h82);
		lt = 8'h48;
		for (int i = 0; i < 2; i++) begin
			os();
			chk(8'(alert_oe), {7'h00, i == 1});
		end
		// a lower address wins the alert response: this device keeps its alarm
		lt = 8'h30;
		os();
		u_host.start();
		u_host.xb(8'h19, d, ack);
		u_host.xb(8'h00, d, nk);
		u_host.stop();
		chk(8'(alert_oe), 8'h01);
		// open diode: remote reads full scale, fault and remote trip flagged
		op = 1'b1;
		os();
		op = 1'b0;
		rd(8'h01);
		chk(d, 8'hFF);
		chk(8'(trip), 8'h01);
		rd(8'h02);
		chk(d, 8'h46);
		// masked and running: trip follows, alarm line stays released
		wr(8'h09, 8'h80, 1'b1);
		// one-shot between automatic conversions restarts the full interval
		os();
		c0 = n_conv;
		repeat (40) @(posedge clock_i);
		#1;
		chk(8'(n_conv - c0), 8'h00);
		for (int i = 0; i < 16; i++) begin
			lt = (i < 6) ? cn[i] : 8'h40 + 8'($unsigned($random(seed)) % 48);
			c0 = n_conv;
			wait_conv();
			tr = exp_trip(lt, tr);
			chk(8'(trip), 8'(tr));
			chk(8'(alert_oe), 8'h00);
		end
		chk(8'({al, sdo}), 8'h00);
		finish_test();
	end
endmodule : tb_talr_core
